// ---- rtl/ubsc_pkg.sv ----
// Constants, field layouts and state record for the utility bus select block.
// Assumes a single 100 MHz mclk that also serves as the ISA system clock.
//
// Overview of operation
// - Bank pick output low selects first decoder, high selects second decoder.
// - Bank pick and select code follow the decode of the ISA address lines.
// - Clock-chip latch strobe forces bank pick active two clocks from write falling.
// - Bank pick stays high for invalid addresses or non utility bus accesses.
// - Writing one to control bit 0 pulses soft CPU reset low for four clocks.
// - No new soft reset pulse until control bit 0 has been written back to zero.
// - Reset drives soft CPU reset high and clears control bit 0.
// - Control bit 1 written zero drives address-20 gate low, one drives it high.
// - Address-20 gate output is low while and after reset.
// - Floppy location offset 7 reads with IDE decode disabled put the inverted media change input on data bit 7.
// - Decode enable register A chooses primary or secondary floppy location.
// - Three-bit select code drives the decoders and is all ones during reset.
// - Media change strap low at reset end disables floppy readback and selects.

package ubsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] SYSCTL_OFS = 8'h92;
    localparam logic [7:0] DECA_OFS = 8'h40;
    localparam logic [7:0] STATUS_OFS = 8'h41;

    // Fields
    localparam int SYSCTL_RST_BIT = 0;
    localparam int SYSCTL_A20_BIT = 1;
    localparam int DECA_FLOPPY_EN_BIT = 0;
    localparam int DECA_FLOPPY_SEC_BIT = 1;
    localparam int DECA_IDE_EN_BIT = 2;

    // Reset values
    localparam logic [7:0] SYSCTL_RST_VAL = 8'h00;
    localparam logic [7:0] DECA_RST_VAL = 8'h05;
    localparam logic [2:0] CODE_IDLE = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Timing, in system clock periods
    localparam logic [2:0] SOFT_RST_CYCLES = 3'h4;
    localparam logic [1:0] LATCH_CYCLES = 2'h2;
    localparam logic [1:0] STRAP_DELAY = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // I/O locations
    localparam logic [15:0] KBC_DATA_IO = 16'h0060;
    localparam logic [15:0] KBC_CMD_IO = 16'h0064;
    localparam logic [15:0] CLK_ADDR_IO = 16'h0070;
    localparam logic [15:0] CLK_DATA_IO = 16'h0071;
    localparam logic [15:0] FLOPPY_PRI_BASE = 16'h03F0;
    localparam logic [15:0] FLOPPY_SEC_BASE = 16'h0370;
    localparam logic [15:0] IDE_BASE = 16'h01F0;
    localparam logic [2:0] MEDIA_OFS = 3'h7;
    localparam logic [2:0] FDC_IDE_HOLE = 3'h6;

    // Select codes and banks
    localparam logic [2:0] CODE_CLK = 3'h0;
    localparam logic [2:0] CODE_KBC = 3'h1;
    localparam logic [2:0] CODE_FLOPPY = 3'h2;
    localparam logic [2:0] CODE_IDE = 3'h0;
    localparam logic BANK_FIRST = 1'b0;
    localparam logic BANK_SECOND = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic hit;
        logic bank;
        logic [2:0] code;
    } ubsc_dec_t;

    typedef struct packed {
        logic [16:0] sa_s1;
        logic [16:0] sa_s2;
        logic av_s1;
        logic av_s2;
        logic ior_s1;
        logic ior_s2;
        logic iow_s1;
        logic iow_s2;
        logic iow_d;
        logic mc_s1;
        logic mc_s2;
        logic [1:0] boot_cnt;
        logic boot_done;
        logic strap;
        logic [7:0] sysctl;
        logic [7:0] deca;
        logic [2:0] rst_cnt;
        logic [1:0] latch_cnt;
        logic bank_n;
        logic [2:0] code;
        logic latch_n;
        logic sd7_out;
        logic sd7_oe_n;
        logic [7:0] rdata;
    } ubsc_state_t;

endpackage

// ---- rtl/ubsc_top.sv ----
// Utility bus decoder bank select, select code, clock latch, soft CPU reset,
// address-20 gate and media change readback on data bit 7.
// Assumes ISA address and commands arrive asynchronously; mclk is the system clock.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ubsc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // ISA side
    input wire logic [16:0] isa_sa,
    input wire logic isa_addr_valid,
    input wire logic isa_ior_n,
    input wire logic isa_iow_n,
    input wire logic media_change_in,
    output logic sd7_out,
    output logic sd7_oe_n,
    // Utility bus decoders
    output logic decoder_bank_pick_n,
    output logic [2:0] peripheral_select_code,
    output logic clock_chip_latch_n,
    // CPU glue
    output logic soft_cpu_reset_n,
    output logic addr20_gate_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic ubsc_pkg::ubsc_dec_t ubsc_decode(input logic [15:0] io, input logic [7:0] deca,
                                                       input logic floppy_ok);
        ubsc_pkg::ubsc_dec_t d;
        logic [15:0] fbase;
        d.hit = 1'b0;
        d.bank = ubsc_pkg::BANK_SECOND;
        d.code = ubsc_pkg::CODE_IDLE;
        fbase = deca[ubsc_pkg::DECA_FLOPPY_SEC_BIT] ? ubsc_pkg::FLOPPY_SEC_BASE : ubsc_pkg::FLOPPY_PRI_BASE;
        if (io == ubsc_pkg::CLK_ADDR_IO || io == ubsc_pkg::CLK_DATA_IO) begin
            d.hit = 1'b1;
            d.bank = ubsc_pkg::BANK_FIRST;
            d.code = ubsc_pkg::CODE_CLK;
        end else if (io == ubsc_pkg::KBC_DATA_IO || io == ubsc_pkg::KBC_CMD_IO) begin
            d.hit = 1'b1;
            d.bank = ubsc_pkg::BANK_FIRST;
            d.code = ubsc_pkg::CODE_KBC;
        end else if (io[15:3] == fbase[15:3] && io[2:0] != ubsc_pkg::FDC_IDE_HOLE
                     && deca[ubsc_pkg::DECA_FLOPPY_EN_BIT] && floppy_ok) begin
            d.hit = 1'b1;
            d.bank = ubsc_pkg::BANK_FIRST;
            d.code = ubsc_pkg::CODE_FLOPPY;
        end else if (io[15:3] == ubsc_pkg::IDE_BASE[15:3] && deca[ubsc_pkg::DECA_IDE_EN_BIT]) begin
            d.hit = 1'b1;
            d.bank = ubsc_pkg::BANK_SECOND;
            d.code = ubsc_pkg::CODE_IDE;
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    ubsc_pkg::ubsc_state_t st_r;
    ubsc_pkg::ubsc_state_t st_nxt;
    ubsc_pkg::ubsc_dec_t dec;
    logic [15:0] fbase;
    logic iow_fall;
    logic sysctl_wr;

    always_comb begin
        st_nxt = st_r;
        // Two-flop synchronisers
        st_nxt.sa_s1 = isa_sa;
        st_nxt.sa_s2 = st_r.sa_s1;
        st_nxt.av_s1 = isa_addr_valid;
        st_nxt.av_s2 = st_r.av_s1;
        st_nxt.ior_s1 = isa_ior_n;
        st_nxt.ior_s2 = st_r.ior_s1;
        st_nxt.iow_s1 = isa_iow_n;
        st_nxt.iow_s2 = st_r.iow_s1;
        st_nxt.iow_d = st_r.iow_s2;
        st_nxt.mc_s1 = media_change_in;
        st_nxt.mc_s2 = st_r.mc_s1;

        // Strap capture once the synchroniser holds a settled value
        if (!st_r.boot_done) begin
            if (st_r.boot_cnt == ubsc_pkg::STRAP_DELAY) begin
                st_nxt.strap = st_r.mc_s2;
                st_nxt.boot_done = 1'b1;
            end else begin
                st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
            end
        end

        // Register writes
        sysctl_wr = reg_wr && reg_addr == ubsc_pkg::SYSCTL_OFS;
        if (sysctl_wr) begin
            st_nxt.sysctl = {6'h00, reg_wdata[ubsc_pkg::SYSCTL_A20_BIT:ubsc_pkg::SYSCTL_RST_BIT]};
        end
        if (reg_wr && reg_addr == ubsc_pkg::DECA_OFS) begin
            st_nxt.deca = {5'h00, reg_wdata[2:0]};
        end

        // Soft reset pulse on a zero-to-one change of bit 0 only
        if (st_r.rst_cnt != 3'h0) begin
            st_nxt.rst_cnt = st_r.rst_cnt - 3'h1;
        end else if (sysctl_wr && reg_wdata[ubsc_pkg::SYSCTL_RST_BIT]
                     && !st_r.sysctl[ubsc_pkg::SYSCTL_RST_BIT]) begin
            st_nxt.rst_cnt = ubsc_pkg::SOFT_RST_CYCLES;
        end

        // Register reads, data one cycle later
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ubsc_pkg::SYSCTL_OFS: st_nxt.rdata = st_r.sysctl;
                ubsc_pkg::DECA_OFS: st_nxt.rdata = st_r.deca;
                ubsc_pkg::STATUS_OFS: st_nxt.rdata = {5'h00, st_r.strap, st_r.mc_s2, st_r.rst_cnt != 3'h0};
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // Decoder bank and select code
        dec = ubsc_decode(st_r.sa_s2[15:0], st_r.deca, st_r.strap && st_r.boot_done);
        iow_fall = st_r.iow_d && !st_r.iow_s2;
        if (st_r.av_s2 && iow_fall && st_r.sa_s2[15:0] == ubsc_pkg::CLK_ADDR_IO) begin
            st_nxt.latch_cnt = ubsc_pkg::LATCH_CYCLES;
        end else if (st_r.latch_cnt != 2'h0) begin
            st_nxt.latch_cnt = st_r.latch_cnt - 2'h1;
        end
        if (st_nxt.latch_cnt != 2'h0) begin
            st_nxt.bank_n = ubsc_pkg::BANK_FIRST;
            st_nxt.code = ubsc_pkg::CODE_CLK;
            st_nxt.latch_n = 1'b0;
        end else if (st_r.av_s2 && dec.hit) begin
            st_nxt.bank_n = dec.bank;
            st_nxt.code = dec.code;
            st_nxt.latch_n = 1'b1;
        end else begin
            st_nxt.bank_n = 1'b1;
            st_nxt.code = ubsc_pkg::CODE_IDLE;
            st_nxt.latch_n = 1'b1;
        end

        // Media change readback on data bit 7
        fbase = st_r.deca[ubsc_pkg::DECA_FLOPPY_SEC_BIT] ? ubsc_pkg::FLOPPY_SEC_BASE : ubsc_pkg::FLOPPY_PRI_BASE;
        if (st_r.av_s2 && !st_r.ior_s2 && st_r.sa_s2[15:0] == {fbase[15:3], ubsc_pkg::MEDIA_OFS}
            && st_r.deca[ubsc_pkg::DECA_FLOPPY_EN_BIT] && !st_r.deca[ubsc_pkg::DECA_IDE_EN_BIT]
            && st_r.strap && st_r.boot_done) begin
            st_nxt.sd7_out = !st_r.mc_s2;
            st_nxt.sd7_oe_n = 1'b0;
        end else begin
            st_nxt.sd7_out = 1'b0;
            st_nxt.sd7_oe_n = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.sa_s1 <= 17'h00000;
            st_r.sa_s2 <= 17'h00000;
            st_r.av_s1 <= 1'b0;
            st_r.av_s2 <= 1'b0;
            st_r.ior_s1 <= 1'b1;
            st_r.ior_s2 <= 1'b1;
            st_r.iow_s1 <= 1'b1;
            st_r.iow_s2 <= 1'b1;
            st_r.iow_d <= 1'b1;
            st_r.mc_s1 <= 1'b0;
            st_r.mc_s2 <= 1'b0;
            st_r.boot_cnt <= 2'h0;
            st_r.boot_done <= 1'b0;
            st_r.strap <= 1'b0;
            st_r.sysctl <= ubsc_pkg::SYSCTL_RST_VAL;
            st_r.deca <= ubsc_pkg::DECA_RST_VAL;
            st_r.rst_cnt <= 3'h0;
            st_r.latch_cnt <= 2'h0;
            st_r.bank_n <= 1'b1;
            st_r.code <= ubsc_pkg::CODE_IDLE;
            st_r.latch_n <= 1'b1;
            st_r.sd7_out <= 1'b0;
            st_r.sd7_oe_n <= 1'b1;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = st_r.rdata;
    assign sd7_out = st_r.sd7_out;
    assign sd7_oe_n = st_r.sd7_oe_n;
    assign decoder_bank_pick_n = st_r.bank_n;
    assign peripheral_select_code = st_r.code;
    assign clock_chip_latch_n = st_r.latch_n;
    assign soft_cpu_reset_n = (st_r.rst_cnt == 3'h0);
    assign addr20_gate_out = st_r.sysctl[ubsc_pkg::SYSCTL_A20_BIT];

endmodule

`default_nettype wire

// ---- verif/ubsc_glue_model.sv ----
// CPU glue model: reset AND and address-20 mask OR outside the block.
// Assumes it is wired to the block outputs by the testbench.
`timescale 1ns/1ns
`default_nettype none
module ubsc_glue_model (
    // Block outputs
    input wire logic soft_cpu_reset_n,
    input wire logic addr20_gate_out,
    // Keyboard controller and CPU
    input wire logic kbc_reset_n,
    input wire logic kbc_addr20_gate,
    output logic cpu_reset_line,
    output logic cpu_addr20_mask_n
);
    assign cpu_reset_line = !(soft_cpu_reset_n && kbc_reset_n);
    assign cpu_addr20_mask_n = addr20_gate_out || kbc_addr20_gate || cpu_reset_line;
endmodule
`default_nettype wire

// ---- verif/ubsc_chk.sv ----
// Port assertions for the utility bus select block.
// Assumes one mclk domain and the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module ubsc_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // ISA side
    input wire logic isa_addr_valid,
    input wire logic isa_ior_n,
    input wire logic media_change_in,
    input wire logic sd7_out,
    input wire logic sd7_oe_n,
    // Outputs
    input wire logic decoder_bank_pick_n,
    input wire logic [2:0] peripheral_select_code,
    input wire logic clock_chip_latch_n,
    input wire logic soft_cpu_reset_n,
    input wire logic addr20_gate_out
);
    logic sys_wr;
    logic set_wr;
    logic [1:0] wd;
    assign sys_wr = reg_wr && reg_addr == ubsc_pkg::SYSCTL_OFS;
    assign wd = reg_wdata[1:0];
    assign set_wr = sys_wr && wd[0];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RST_LEN: assert property ($fell(soft_cpu_reset_n) |-> !soft_cpu_reset_n [*4] ##1 soft_cpu_reset_n)
        else $error("soft reset pulse length wrong");
    AST_RST_CAUSE: assert property ($fell(soft_cpu_reset_n) |-> $past(set_wr))
        else $error("soft reset pulse without control write");
    AST_A20: assert property ($past(sys_wr) |-> addr20_gate_out == $past(wd[1]))
        else $error("address-20 gate not following control bit 1");
    AST_SD7_VAL: assert property (!sd7_oe_n |-> sd7_out == !$past(media_change_in, 3))
        else $error("data bit 7 not inverted media change");
    AST_SD7_RD: assert property (!sd7_oe_n |-> !$past(isa_ior_n, 3))
        else $error("data bit 7 driven outside a read");
    AST_LATCH: assert property ($fell(clock_chip_latch_n) |-> !decoder_bank_pick_n ##1
        (!clock_chip_latch_n && !decoder_bank_pick_n) ##1 clock_chip_latch_n)
        else $error("latch window not two clocks with bank active");
    AST_LATCH_CODE: assert property (!clock_chip_latch_n |-> peripheral_select_code == ubsc_pkg::CODE_CLK)
        else $error("select code wrong in latch window");
    AST_IDLE: assert property ((!isa_addr_valid [*4]) ##0 clock_chip_latch_n |-> decoder_bank_pick_n)
        else $error("bank pick active without valid address");
    COV_PULSE: cover property ($fell(soft_cpu_reset_n));
    COV_LATCH: cover property ($fell(clock_chip_latch_n));
    COV_SD7: cover property (!sd7_oe_n);
endmodule
bind ubsc_top ubsc_chk ubsc_chk_i (.*);
`default_nettype wire

// ---- verif/utility_bus_select_and_sysctl_test.sv ----
// Self-checking bench for the utility bus select block.
// Assumes the design package, the glue model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module utility_bus_select_and_sysctl_test;
    logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, isa_addr_valid = 1'b0;
    logic isa_ior_n = 1'b1, isa_iow_n = 1'b1, media_change_in = 1'b1, kbc_reset_n = 1'b1, kbc_addr20_gate = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, r;
    logic [16:0] isa_sa = 17'h00000;
    logic sd7_out, sd7_oe_n, decoder_bank_pick_n, clock_chip_latch_n, soft_cpu_reset_n, addr20_gate_out;
    logic cpu_reset_line, cpu_addr20_mask_n, w, m;
    logic [2:0] peripheral_select_code;
    logic [15:0] a;
    logic [15:0] al [8] = '{16'h0060, 16'h0064, 16'h0070, 16'h03F7, 16'h0377, 16'h0300, 16'h03F2, 16'h01F4};
    int bad_count = 0, tests_run = 0, n;
    ubsc_top ubsc_top_i (.*);
    ubsc_glue_model ubsc_glue_model_i (.*);
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask
    task automatic pulse(input logic [7:0] v, input logic [7:0] exp);
        wr(ubsc_pkg::SYSCTL_OFS, v);
        n = 0;
        repeat (8) begin
            #1 if (!soft_cpu_reset_n) n++;
            @(posedge mclk);
        end
        chk("soft reset cycles", exp, 8'(n));
    endtask
    task automatic io(input logic [15:0] ad, input logic wt, output logic [7:0] res);
        @(posedge mclk);
        isa_sa <= {1'b0, ad};
        isa_addr_valid <= 1'b1;
        @(posedge mclk);
        if (wt) isa_iow_n <= 1'b0;
        else isa_ior_n <= 1'b0;
        n = 0;
        repeat (6) begin
            @(posedge mclk);
            #1 if (!clock_chip_latch_n) n++;
        end
        res = {n[1:0], decoder_bank_pick_n, sd7_oe_n, sd7_out & !sd7_oe_n, peripheral_select_code};
        @(posedge mclk);
        isa_iow_n <= 1'b1;
        isa_ior_n <= 1'b1;
        isa_addr_valid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    function automatic logic [7:0] exp_io(input logic [15:0] ad, input logic wt, input logic [7:0] dc, input logic mv);
        logic [15:0] fb;
        logic sd;
        fb = dc[1] ? ubsc_pkg::FLOPPY_SEC_BASE : ubsc_pkg::FLOPPY_PRI_BASE;
        sd = ad[2:0] == ubsc_pkg::MEDIA_OFS && !wt && !dc[2];
        if (ad == ubsc_pkg::CLK_ADDR_IO) return {wt, 4'b0010, ubsc_pkg::CODE_CLK};
        if (ad == ubsc_pkg::KBC_DATA_IO || ad == ubsc_pkg::KBC_CMD_IO) return {5'b00010, ubsc_pkg::CODE_KBC};
        if (dc[0] && ad[15:3] == fb[15:3] && ad[2:0] != ubsc_pkg::FDC_IDE_HOLE)
            return {3'b000, !sd, sd && !mv, ubsc_pkg::CODE_FLOPPY};
        if (dc[2] && ad[15:3] == ubsc_pkg::IDE_BASE[15:3]) return {5'b00110, ubsc_pkg::CODE_IDE};
        return {5'b00110, ubsc_pkg::CODE_IDLE};
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(71972));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 chk("reset outputs", 8'hBF, {soft_cpu_reset_n, addr20_gate_out, decoder_bank_pick_n, clock_chip_latch_n,
            sd7_oe_n, peripheral_select_code});
        rd(ubsc_pkg::SYSCTL_OFS, 8'h00);
        rd(8'hF0, 8'h00);
        rd(ubsc_pkg::STATUS_OFS, 8'h06);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom) & 8'h02;
            wr(ubsc_pkg::SYSCTL_OFS, d);
            #1 chk("addr20_gate_out", {7'h00, d[1]}, {7'h00, addr20_gate_out});
            chk("cpu_addr20_mask_n", {7'h00, d[1]}, {7'h00, cpu_addr20_mask_n});
            rd(ubsc_pkg::SYSCTL_OFS, d);
        end
        pulse(8'h01, 8'h04);
        pulse(8'h01, 8'h00);
        pulse(8'h00, 8'h00);
        pulse(8'h03, 8'h04);
        wr(ubsc_pkg::DECA_OFS, 8'h01);
        io(ubsc_pkg::CLK_ADDR_IO, 1'b1, r);
        chk("clock latch write", exp_io(ubsc_pkg::CLK_ADDR_IO, 1'b1, 8'h01, 1'b1), r);
        media_change_in <= 1'b0;
        io(16'h03F7, 1'b0, r);
        chk("media readback primary", exp_io(16'h03F7, 1'b0, 8'h01, 1'b0), r);
        wr(ubsc_pkg::DECA_OFS, 8'h03);
        media_change_in <= 1'b1;
        io(16'h0377, 1'b0, r);
        chk("media readback secondary", exp_io(16'h0377, 1'b0, 8'h03, 1'b1), r);
        for (int i = 0; i < 24; i++) begin
            d = 8'($urandom) & 8'h07;
            wr(ubsc_pkg::DECA_OFS, d);
            rd(ubsc_pkg::DECA_OFS, d);
            m = 1'($urandom);
            w = 1'($urandom);
            a = al[$urandom % 8];
            media_change_in <= m;
            io(a, w, r);
            chk("isa decode", exp_io(a, w, d, m), r);
        end
        @(posedge mclk);
        rst_n <= 1'b0;
        media_change_in <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(ubsc_pkg::SYSCTL_OFS, 8'h00);
        chk("addr20 after reset", 8'h00, {7'h00, addr20_gate_out});
        rd(ubsc_pkg::STATUS_OFS, 8'h00);
        wr(ubsc_pkg::DECA_OFS, 8'h01);
        io(16'h03F7, 1'b0, r);
        chk("strap low floppy read", 8'h37, r);
        report_and_stop();
    end
endmodule
`default_nettype wire
